// File: rtl/adc_regs.svh
`ifndef ADC_REGS_SVH
`define ADC_REGS_SVH

`define CONTROL_ADDR 8'h1f
`define PORT_CFG_ADDR 8'h9f
`define PORT_ADDR 8'h05
`define RESULT_ADDR 8'h1e
`define FLAG_ADDR 8'h0c

`define CONTROL_RESET 8'h00
`define PORT_CFG_RESET 3'h0
`define RESULT_RESET 8'h00

`define CLKSEL_MSB 7
`define CLKSEL_LSB 6
`define RSVD_HI_BIT 5
`define CHAN_MSB 4
`define CHAN_LSB 3
`define GO_BIT 2
`define RSVD_LO_BIT 1
`define POWER_BIT 0
`define FLAG_BIT 0

// half a conversion-clock period in core clocks (tosc = one core clock)
`define HALF_DIV2 6'h01
`define HALF_DIV8 6'h04
`define HALF_DIV32 6'h10
// 9.5 conversion-clock periods, counted in halves
`define CONV_HALVES 5'h13
// 2 conversion-clock periods, counted in halves
`define HOLDOFF_HALVES 5'h04
// one instruction cycle is four oscillator periods
`define INSTR_CLKS 3'h4

`endif

// File: rtl/adc_pkg.sv
package adc_pkg;
	typedef enum logic [1:0] {CLK_DIV2, CLK_DIV8, CLK_DIV32, CLK_RC} conv_clock_t;
	typedef enum logic [1:0] {ST_IDLE, ST_RC_WAIT, ST_CONVERT, ST_HOLDOFF} conv_state_t;
endpackage

// File: rtl/sar_if.sv
`timescale 1ns/1ps
interface sar_if;
	logic start;
	logic step;
	logic cmp_above;
	logic [7:0] code;
	modport ctrl (output start, output step, output cmp_above, input code);
	modport engine (input start, input step, input cmp_above, output code);
endinterface

// File: rtl/sar_engine.sv
`timescale 1ns/1ps
module sar_engine (
	input wire logic core_clk,
	input wire logic rst,
	sar_if.engine sar
);
	logic [7:0] trial_bit;
	wire [7:0] drop_mask = trial_bit & {8{~sar.cmp_above}};

	// one trial per step, msb first; code holds the final answer after 8 steps
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			sar.code <= 8'h00;
			trial_bit <= 8'h00;
		end else if (sar.start) begin
			sar.code <= 8'h80;
			trial_bit <= 8'h80;
		end else if (sar.step && trial_bit != 8'h00) begin
			sar.code <= (sar.code & ~drop_mask) | (trial_bit >> 1);
			trial_bit <= trial_bit >> 1;
		end
	end
endmodule

// File: rtl/adc_conversion_control.sv
// Strobed register access is this design's own decision.
`timescale 1ns/1ps
`include "adc_regs.svh"
// Operation
// - clock select: osc/2, /8, /32, rc
// - channel field routes pins 0,1,2,4
// - go bit starts conversion, reads busy
// - hardware clears go at completion
// - power bit off shuts converter down
// - completion loads result, clears go, flags
// - port config sets analog pins, reference
// - port config resets to all analog
// - analog pins read zero in port
// - eight-bit successive approximation, selectable reference
// - two period holdoff after conversion
// - converter may run during sleep
// - upper port config bits read zero
// - clearing go aborts, result kept
// - conversion lasts nine and half periods
// - rc waits instruction; sleep wake or off
// - sleep on non-rc clock aborts, powers off
module adc_conversion_control
	import adc_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic [7:0] port_pins,
	input wire logic rc_half_tick,
	input wire logic cmp_above,
	input wire logic sleep_mode,
	input wire logic conversion_done_enable,
	output logic [7:0] dac_code,
	output logic [5:0] sample_route,
	output logic [5:0] analog_pin_mask,
	output logic vref_external,
	output logic converter_on,
	output logic conversion_done_flag,
	output logic wake_request
);
	sar_if sar ();

	logic [1:0] conv_clock_select;
	logic [1:0] channel_select;
	logic go;
	logic converter_power_on;
	logic [1:0] rsvd_bits;
	logic [2:0] port_analog_config_field;
	logic [7:0] conversion_result;
	logic sleep_off;
	conv_state_t state;
	logic [4:0] half_cnt;
	logic [5:0] div_cnt;
	logic [2:0] wait_cnt;
	logic done_q;

	sar_engine engine (
		.core_clk(core_clk),
		.rst(rst),
		.sar(sar)
	);

	////////////////////////////////////////////////////////////////////////
	// decode

	wire wr_ctrl = reg_wr && reg_addr == `CONTROL_ADDR;
	wire wr_cfg = reg_wr && reg_addr == `PORT_CFG_ADDR;
	wire wr_result = reg_wr && reg_addr == `RESULT_ADDR;
	wire wr_flag = reg_wr && reg_addr == `FLAG_ADDR;
	wire rc_sel = conv_clock_select == CLK_RC;
	wire busy = state == ST_RC_WAIT || state == ST_CONVERT;
	wire running = state == ST_CONVERT || state == ST_HOLDOFF;
	wire sleep_kill = sleep_mode && !rc_sel && converter_power_on;
	wire sw_abort = wr_ctrl && (!reg_wdata[`GO_BIT] || !reg_wdata[`POWER_BIT]);
	wire abort_evt = busy && (sw_abort || sleep_kill);
	wire start_req = wr_ctrl && reg_wdata[`GO_BIT] && reg_wdata[`POWER_BIT]
		&& converter_power_on && !sleep_off && state == ST_IDLE;

	////////////////////////////////////////////////////////////////////////
	// conversion clock

	wire [5:0] half_limit = conv_clock_select == CLK_DIV2 ? `HALF_DIV2 :
		conv_clock_select == CLK_DIV8 ? `HALF_DIV8 : `HALF_DIV32;
	wire div_wrap = div_cnt == half_limit - 6'h01;
	wire half_tick = running && (rc_sel ? rc_half_tick : div_wrap);

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			div_cnt <= 6'h00;
		end else if (!running || div_wrap) begin
			div_cnt <= 6'h00;
		end else begin
			div_cnt <= div_cnt + 6'h01;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// sequencer

	wire conv_end = state == ST_CONVERT && half_tick && half_cnt == `CONV_HALVES - 5'h01;
	wire hold_end = state == ST_HOLDOFF && half_tick
		&& half_cnt == `HOLDOFF_HALVES - 5'h01;
	wire rc_wait_end = state == ST_RC_WAIT && wait_cnt == `INSTR_CLKS - 3'h1;

	assign sar.start = (start_req && !rc_sel) || rc_wait_end;
	// one trial on each odd half from 1 to 15
	assign sar.step = state == ST_CONVERT && half_tick && half_cnt[0]
		&& half_cnt < 5'h10;
	assign sar.cmp_above = cmp_above;

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			state <= ST_IDLE;
		end else begin
			case (state)
				ST_IDLE: begin
					if (start_req) begin
						state <= rc_sel ? ST_RC_WAIT : ST_CONVERT;
					end
				end
				ST_RC_WAIT: begin
					if (abort_evt) begin
						state <= ST_HOLDOFF;
					end else if (rc_wait_end) begin
						state <= ST_CONVERT;
					end
				end
				ST_CONVERT: begin
					if (abort_evt || conv_end) begin
						state <= ST_HOLDOFF;
					end
				end
				ST_HOLDOFF: begin
					if (hold_end) begin
						state <= ST_IDLE;
					end
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			half_cnt <= 5'h00;
		end else if (sar.start || abort_evt || conv_end || hold_end) begin
			half_cnt <= 5'h00;
		end else if (half_tick) begin
			half_cnt <= half_cnt + 5'h01;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			wait_cnt <= 3'h0;
		end else if (state == ST_RC_WAIT) begin
			wait_cnt <= wait_cnt + 3'h1;
		end else begin
			wait_cnt <= 3'h0;
		end
	end

	// completion registered before updates; abort in last half cancels it
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			done_q <= 1'b0;
		end else begin
			done_q <= conv_end && !abort_evt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// registers

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			conv_clock_select <= 2'(`CONTROL_RESET >> `CLKSEL_LSB);
			channel_select <= 2'h0;
			converter_power_on <= 1'b0;
			rsvd_bits <= 2'h0;
		end else if (wr_ctrl) begin
			conv_clock_select <= reg_wdata[`CLKSEL_MSB:`CLKSEL_LSB];
			channel_select <= reg_wdata[`CHAN_MSB:`CHAN_LSB];
			converter_power_on <= reg_wdata[`POWER_BIT];
			rsvd_bits <= {reg_wdata[`RSVD_HI_BIT], reg_wdata[`RSVD_LO_BIT]};
		end
	end

	// hardware clears go at completion; same event
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			go <= 1'b0;
		end else if (done_q || abort_evt) begin
			go <= 1'b0;
		end else if (start_req) begin
			go <= 1'b1;
		end else if (wr_ctrl && !busy) begin
			go <= 1'b0;
		end
	end

	// all analog after reset; only three bits stored
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			port_analog_config_field <= `PORT_CFG_RESET;
		end else if (wr_cfg) begin
			port_analog_config_field <= reg_wdata[2:0];
		end
	end

	// load result; an abort never reaches this load
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			conversion_result <= `RESULT_RESET;
		end else if (done_q) begin
			conversion_result <= sar.code;
		end else if (wr_result) begin
			conversion_result <= reg_wdata;
		end
	end

	// flag set wins over a software clear
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			conversion_done_flag <= 1'b0;
		end else if (done_q) begin
			conversion_done_flag <= 1'b1;
		end else if (wr_flag) begin
			conversion_done_flag <= reg_wdata[`FLAG_BIT];
		end
	end

	// no wake enabled: power down in sleep, power bit stays
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			sleep_off <= 1'b0;
		end else if (!sleep_mode) begin
			sleep_off <= 1'b0;
		end else if (sleep_kill || (done_q && !conversion_done_enable)) begin
			sleep_off <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs and read port

	// power bit gates the analog section
	assign converter_on = converter_power_on && !sleep_off;
	assign wake_request = conversion_done_flag && conversion_done_enable && sleep_mode;
	assign dac_code = sar.code;

	// analog pin map per configuration code
	wire [2:0] pcf = port_analog_config_field;
	assign analog_pin_mask = pcf[2:1] == 2'h0 ? 6'h17 :
		pcf[2:1] == 2'h1 ? 6'h07 :
		pcf[2:1] == 2'h2 ? 6'h03 :
		pcf == 3'h6 ? 6'h01 : 6'h00;
	// odd codes below seven use pin 1 as reference
	assign vref_external = pcf[0] && pcf != 3'h7;

	// channel three maps to pin 4; switch open while busy
	wire [2:0] route_pin = channel_select == 2'h3 ? 3'h4 : {1'b0, channel_select};
	wire acquiring = converter_on && !running && state != ST_RC_WAIT;
	assign sample_route = acquiring ? 6'h01 << route_pin : 6'h00;

	wire [7:0] ctrl_read = {conv_clock_select, rsvd_bits[1], channel_select, go,
		rsvd_bits[0], converter_power_on};
	wire [7:0] port_read = {port_pins[7:6], port_pins[5:0] & ~analog_pin_mask};
	wire [7:0] read_mux = reg_addr == `CONTROL_ADDR ? ctrl_read :
		reg_addr == `PORT_CFG_ADDR ? {5'h00, pcf} :
		reg_addr == `PORT_ADDR ? port_read :
		reg_addr == `RESULT_ADDR ? conversion_result :
		reg_addr == `FLAG_ADDR ? {7'h00, conversion_done_flag} : 8'h00;

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			reg_rdata <= 8'h00;
		end else begin
			reg_rdata <= reg_rd ? read_mux : 8'h00;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks

	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);

	go_done_clear_a: assert property (done_q |=> !go)
		else $error("go not cleared after completion");
	result_load_a: assert property (done_q |=> conversion_result == $past(sar.code))
		else $error("result not loaded");
	flag_set_a: assert property (done_q |=> conversion_done_flag)
		else $error("done flag not set");
	go_needs_power_a: assert property ($rose(go) |-> converter_power_on)
		else $error("go set while converter off");
	abort_keeps_a: assert property (abort_evt |=> ##1 conversion_result == $past(conversion_result, 2)
		|| $past(wr_result))
		else $error("abort changed result");
	holdoff_open_a: assert property ($rose(state == ST_HOLDOFF) |-> (sample_route == 6'h00)[*4])
		else $error("channel reconnected during holdoff");
	cfg_upper_zero_a: assert property (reg_rd && reg_addr == `PORT_CFG_ADDR
		|=> reg_rdata[7:3] == 5'h00)
		else $error("upper config bits not zero");
	analog_read_a: assert property (reg_rd && reg_addr == `PORT_ADDR
		|=> (reg_rdata[5:0] & $past(analog_pin_mask)) == 6'h00)
		else $error("analog pin read nonzero");
	sleep_kill_a: assert property (sleep_kill ##1 sleep_mode |-> !converter_on)
		else $error("converter on after sleep abort");
	conv_len_a: assert property (!rc_sel && conv_clock_select == CLK_DIV2 && sar.start
		&& !sleep_mode |-> ##20 (done_q || $past(abort_evt, 1) || state != ST_CONVERT))
		else $error("conversion length wrong");

	done_c: cover property (done_q);
	abort_c: cover property (abort_evt && sw_abort);
	wake_c: cover property ($rose(wake_request));
	rc_conv_c: cover property (rc_wait_end);
endmodule

// File: verification/adc_conversion_control_tb.sv
`timescale 1ns/1ps
`include "adc_regs.svh"
module adc_conversion_control_tb;
	logic core_clk = 0;
	logic rst = 1;
	logic [7:0] reg_addr = 0;
	logic [7:0] reg_wdata = 0;
	logic reg_wr = 0;
	logic reg_rd = 0;
	logic [7:0] port_pins = 0;
	logic rc_half_tick = 0;
	logic sleep_mode = 0;
	logic conversion_done_enable = 0;
	logic [7:0] target = 0;
	logic [7:0] reg_rdata, dac_code;
	logic [5:0] sample_route, analog_pin_mask;
	logic vref_external, converter_on, conversion_done_flag, wake_request;
	logic pend = 0;
	logic [1:0] rc_cnt = 0;
	logic [7:0] exp_q[$];
	logic [7:0] ctl, prev;
	logic [63:0] mask_tab = 64'h00_01_03_03_07_07_17_17;
	int err_count = 0;
	int checks = 0;
	int seed = 58;
	int n, i, cyc;
	// about 12 us of acquisition at 25 ns per clock
	localparam int ACQ_CLKS = 480;
	// ideal comparator; combinational so the trial code is judged in the same cycle
	wire cmp_above = target >= dac_code;

	adc_conversion_control adc_conversion_control_i (
		.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .port_pins(port_pins),
		.rc_half_tick(rc_half_tick), .cmp_above(cmp_above), .sleep_mode(sleep_mode),
		.conversion_done_enable(conversion_done_enable), .dac_code(dac_code),
		.sample_route(sample_route), .analog_pin_mask(analog_pin_mask),
		.vref_external(vref_external), .converter_on(converter_on),
		.conversion_done_flag(conversion_done_flag), .wake_request(wake_request)
	);

	initial begin
		forever #12.5 core_clk = ~core_clk;
	end

	always @(posedge core_clk) begin
		rc_cnt <= rc_cnt + 2'h1;
		rc_half_tick <= (rc_cnt == 2'h0);
		pend <= reg_rd;
	end

	////////////////////////////////////////////////////////////////
	always @(negedge core_clk) begin
		if (pend)
			chk("reg_rdata", {8'h00, reg_rdata}, {8'h00, exp_q.pop_front()});
	end

	task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			err_count++;
			$display("Error: %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask

	task rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		exp_q.push_back(e);
		@(posedge core_clk);
		reg_rd <= 1'b0;
	endtask

	task summarize;
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////
	initial begin
		repeat (4) @(posedge core_clk);
		rst <= 1'b0;
		port_pins <= $random(seed);
		rd(`CONTROL_ADDR, 8'h00);
		rd(`PORT_CFG_ADDR, 8'h00);
		rd(`RESULT_ADDR, 8'h00);
		rd(`FLAG_ADDR, 8'h00);
		rd(8'h40, 8'h00);
		chk("analog_pin_mask", analog_pin_mask, 6'h17);
		chk("converter_on", converter_on, 0);
		$display("test reset done");
		for (n = 0; n < 8; n++) begin
			// upper bits set on purpose, they must not stick
			wr(`PORT_CFG_ADDR, 8'hf8 | n[7:0]);
			rd(`PORT_CFG_ADDR, n[7:0]);
			#1;
			chk("analog_pin_mask", analog_pin_mask, mask_tab[n*8 +: 6]);
			chk("vref_external", vref_external, (n == 1 || n == 3 || n == 5));
			rd(`PORT_ADDR, port_pins & ~{2'h0, mask_tab[n*8 +: 6]});
		end
		wr(`PORT_CFG_ADDR, 8'h00);
		$display("test port config done");
		for (i = 0; i < 4; i++) begin
			target <= $random(seed);
			conversion_done_enable <= (i == 3);
			ctl = {i[1:0], 1'b0, i[1:0], 3'b001};
			// configure, wait, start, poll, read, clear flag
			wr(`CONTROL_ADDR, ctl);
			// acquisition wait; the previous holdoff also runs out here
			repeat (ACQ_CLKS) @(posedge core_clk);
			#1;
			chk("sample_route", sample_route, (i == 3) ? 6'h10 : 6'h01 << i);
			chk("converter_on", converter_on, 1);
			wr(`CONTROL_ADDR, ctl | 8'h04);
			sleep_mode <= (i == 3);
			rd(`CONTROL_ADDR, ctl | 8'h04);
			#1;
			cyc = 2;
			while (conversion_done_flag !== 1'b1 && cyc < 1000) begin
				@(posedge core_clk);
				#1;
				cyc++;
			end
			if (i < 3)
				chk("conv cycles", 16'(cyc), 16'(19 * (1 << (2 * i)) + 1));
			chk("holdoff route", sample_route, 0);
			chk("wake_request", wake_request, (i == 3));
			@(posedge core_clk);
			sleep_mode <= 1'b0;
			rd(`CONTROL_ADDR, ctl);
			rd(`RESULT_ADDR, target);
			rd(`FLAG_ADDR, 8'h01);
			wr(`FLAG_ADDR, 8'h00);
			rd(`FLAG_ADDR, 8'h00);
			$display("test conversion clock %0d done", i);
		end
		// abort mid-conversion: long enough wait that a finished run would show
		prev = target;
		target <= ~prev;
		wr(`CONTROL_ADDR, 8'h81);
		// acquisition, after the rc holdoff has ended
		repeat (ACQ_CLKS) @(posedge core_clk);
		wr(`CONTROL_ADDR, 8'h85);
		rd(`CONTROL_ADDR, 8'h85);
		repeat (20) @(posedge core_clk);
		wr(`CONTROL_ADDR, 8'h81);
		repeat (400) @(posedge core_clk);
		rd(`RESULT_ADDR, prev);
		rd(`FLAG_ADDR, 8'h00);
		#1;
		chk("route after abort", sample_route, 6'h01);
		$display("test abort done");
		wr(`CONTROL_ADDR, 8'h41);
		wr(`CONTROL_ADDR, 8'h45);
		rd(`CONTROL_ADDR, 8'h45);
		repeat (10) @(posedge core_clk);
		sleep_mode <= 1'b1;
		repeat (3) @(posedge core_clk);
		#1;
		chk("converter_on in sleep", converter_on, 0);
		@(posedge core_clk);
		sleep_mode <= 1'b0;
		repeat (400) @(posedge core_clk);
		rd(`FLAG_ADDR, 8'h00);
		rd(`RESULT_ADDR, prev);
		rd(`CONTROL_ADDR, 8'h41);
		$display("test sleep abort done");
		wr(`CONTROL_ADDR, 8'h00);
		#1;
		chk("converter_on off", converter_on, 0);
		// power and go in one write: start must be refused
		wr(`CONTROL_ADDR, 8'h05);
		rd(`CONTROL_ADDR, 8'h01);
		$display("test power done");
		repeat (2) @(posedge core_clk);
		summarize();
	end

	initial begin
		#(25 * 20000);
		err_count++;
		summarize();
	end
endmodule
